// [ifs_fifo.sv]
// Purpose: Small synchronous FIFO with valid/ready on both sides.
// Assumes: One clock, synchronous active-high reset.
// Notes: Depth must be a power of two; full and empty come from a count.
`timescale 1ns/1ps
module ifs_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  output logic [$clog2(DEPTH):0] level
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0] wr_ff;
  logic [AW-1:0] nxt_wr;
  logic [AW-1:0] rd_ff;
  logic [AW-1:0] nxt_rd;
  logic [AW:0] cnt_ff;
  logic [AW:0] nxt_cnt;
  logic push;
  logic pop;

  // Handshakes straight from the count so back-pressure is exact
  assign in_ready = (cnt_ff != (AW+1)'(DEPTH));
  assign out_valid = (cnt_ff != '0);
  assign out_data = mem_ff[rd_ff];
  assign level = cnt_ff;
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // Pointer and count update
  always_comb begin
    nxt_wr = push ? wr_ff + 1'b1 : wr_ff;
    nxt_rd = pop ? rd_ff + 1'b1 : rd_ff;
    nxt_cnt = cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
  end

  // Storage has no reset; only pointers and the count need a defined start
  always_ff @(posedge clk) begin
    if (push) begin
      mem_ff[wr_ff] <= in_data;
    end
    if (srst) begin
      wr_ff <= '0;
      rd_ff <= '0;
      cnt_ff <= '0;
    end else begin
      wr_ff <= nxt_wr;
      rd_ff <= nxt_rd;
      cnt_ff <= nxt_cnt;
    end
  end
endmodule

// [ifs_filter_chk.sv]
// Purpose: Port checks for the filter chain top.
// Assumes: One clock, srst synchronous active high.
// Notes: Strobe spacing uses a counter, armed after the first strobe.
`timescale 1ns/1ps
module ifs_filter_chk #(
  parameter int DEPTH = 16,
  parameter int DIV = 4
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic isinc_en,
  input wire logic in_valid,
  input wire logic in_ready,
  input wire logic [31:0] out_sample,
  input wire logic out_strobe,
  input wire logic underrun,
  input wire logic sat_hit,
  input wire logic [$clog2(DEPTH):0] fifo_level
);
  int gap_ff;
  logic seen_ff;
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  // Cycles since the last strobe
  always_ff @(posedge clk) begin
    if (srst) begin
      gap_ff <= 0;
      seen_ff <= 1'b0;
    end else begin
      gap_ff <= out_strobe ? 1 : gap_ff + 1;
      seen_ff <= seen_ff | out_strobe;
    end
  end
  a_update_period: assert property (seen_ff |-> (out_strobe == (gap_ff == DIV)))
    else $error("strobe spacing differs from the update divider");
  a_underrun_strobe: assert property (underrun |-> out_strobe)
    else $error("underrun without strobe");
  a_sat_isinc_only: assert property (sat_hit |-> out_strobe && isinc_en)
    else $error("sat_hit without strobe or with inverse sinc off");
  a_full_refuse: assert property (fifo_level == DEPTH |-> !in_ready)
    else $error("ready while fifo full");
  a_room_ready: assert property (fifo_level < DEPTH |-> in_ready)
    else $error("not ready while fifo has room");
  a_no_push_grow: assert property (!(in_valid && in_ready) |=> fifo_level <= $past(fifo_level))
    else $error("fifo level grew without a push");
  a_sample_hold: assert property (!out_strobe |-> $stable(out_sample))
    else $error("out_sample changed without strobe");
  a_reset_clear: assert property (disable iff (1'b0) srst |=> fifo_level == '0 && !out_strobe && out_sample == '0)
    else $error("outputs not cleared by reset");
endmodule
bind ifs_filter_top ifs_filter_chk #(.DEPTH(DEPTH), .DIV(DIV)) u_ifs_filter_chk (.clk(clk), .srst(srst),
  .isinc_en(isinc_en), .in_valid(in_valid), .in_ready(in_ready), .out_sample(out_sample),
  .out_strobe(out_strobe), .underrun(underrun), .sat_hit(sat_hit), .fifo_level(fifo_level));

// [ifs_filter_top.sv]
// Purpose: Dual-channel interpolation chain with inverse sinc correction at the update rate.
// Assumes: Upstream correction logic feeds samples by valid/ready; mode inputs held static while streaming.
// Notes: Output leaves one sample pair per update enable; a missing sample gives zero and, once the stream has begun, an underrun pulse.
`timescale 1ns/1ps
module ifs_filter_top
  import ifs_pkg::*;
#(
  parameter int CH = NUM_CH,
  parameter int W = DATA_W,
  parameter int DEPTH = FIFO_DEPTH,
  parameter int DIV = UPDATE_DIV
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic [1:0] interp_sel,
  input wire logic isinc_en,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [CH*W-1:0] in_data,
  output logic [CH*W-1:0] out_sample,
  output logic out_strobe,
  output logic underrun,
  output logic sat_hit,
  output logic [$clog2(DEPTH):0] fifo_level
);
  localparam int DW = $clog2(DIV + 1);

  // Stage boundary streams: index 0 is the FIFO output, k+1 is stage k output
  logic s_valid [NUM_HB+1];
  logic s_ready [NUM_HB+1];
  logic [CH*W-1:0] s_data [NUM_HB+1];
  logic hb_in_valid [NUM_HB];
  logic hb_in_ready [NUM_HB];
  logic hb_out_ready [NUM_HB];

  logic [DW-1:0] div_ff;
  logic [DW-1:0] nxt_div;
  logic tick;
  logic tap_valid;
  logic tap_ready;
  logic [CH*W-1:0] tap_data;
  logic started_ff;
  logic nxt_started;
  logic [CH*W-1:0] out_ff;
  logic [CH*W-1:0] nxt_out;
  logic strobe_ff;
  logic nxt_strobe;
  logic under_ff;
  logic nxt_under;
  logic sat_ff;
  logic nxt_sat;
  logic [CH-1:0] ch_sat;
  logic [CH*W-1:0] isinc_val;

  // Input buffer; its ready is the block's ready to upstream
  ifs_fifo #(
    .WIDTH(CH*W),
    .DEPTH(DEPTH)
  ) u_fifo (
    .clk(clk),
    .srst(srst),
    .in_valid(in_valid),
    .in_ready(in_ready),
    .in_data(in_data),
    .out_valid(s_valid[0]),
    .out_ready(s_ready[0]),
    .out_data(s_data[0]),
    .level(fifo_level)
  );

  for (genvar k = 0; k < NUM_HB; k++) begin : g_hb
    ifs_halfband #(
      .STAGE(k),
      .CH(CH),
      .W(W)
    ) u_hb (
      .clk(clk),
      .srst(srst),
      .in_valid(hb_in_valid[k]),
      .in_ready(hb_in_ready[k]),
      .in_data(s_data[k]),
      .out_valid(s_valid[k+1]),
      .out_ready(hb_out_ready[k]),
      .out_data(s_data[k+1])
    );
  end

  // Stages beyond the selection are idle; the last active one feeds the tap
  always_comb begin
    for (int k = 0; k < NUM_HB; k++) begin
      hb_in_valid[k] = s_valid[k] && (2'(k) <= interp_sel);
      s_ready[k] = (2'(k) <= interp_sel) && hb_in_ready[k];
      if (2'(k) < interp_sel) begin
        hb_out_ready[k] = s_ready[k+1];
      end else if (2'(k) == interp_sel) begin
        hb_out_ready[k] = tap_ready;
      end else begin
        hb_out_ready[k] = 1'b0;
      end
    end
    s_ready[NUM_HB] = 1'b0;
    tap_valid = s_valid[32'(interp_sel) + 1];
    tap_data = s_data[32'(interp_sel) + 1];
  end

  // Update-rate enable; the chain stalls between enables, which fills the FIFO
  always_comb begin
    tick = (div_ff == DW'(DIV - 1));
    nxt_div = tick ? '0 : div_ff + 1'b1;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      div_ff <= '0;
    end else begin
      div_ff <= nxt_div;
    end
  end

  assign tap_ready = tick;

  // Inverse sinc per channel, one step per update enable
  for (genvar c = 0; c < CH; c++) begin : g_isinc
    logic signed [W-1:0] dly_ff [ISINC_TAPS];
    logic signed [W-1:0] line [ISINC_TAPS];
    logic signed [ACC_W-1:0] acc;
    logic [W:0] rs;

    // Line after the new sample enters; zero when the chain had nothing ready
    always_comb begin
      line[0] = tap_valid ? tap_data[c*W +: W] : SAMPLE_RST;
      for (int j = 1; j < ISINC_TAPS; j++) begin
        line[j] = dly_ff[j-1];
      end
      acc = '0;
      // Symmetric correction taps, unity at DC
      for (int j = 0; j < ISINC_TAPS; j++) begin
        acc = acc + ACC_W'(line[j]) * ACC_W'(ISINC_COEF[(j < 5) ? j : (ISINC_TAPS - 1 - j)]);
      end
      rs = ifs_round_sat(acc, ISINC_SHIFT);
      // Bypass takes the centre sample so latency does not change with the enable
      isinc_val[c*W +: W] = isinc_en ? rs[W-1:0] : line[4];
      ch_sat[c] = isinc_en && rs[W];
    end

    always_ff @(posedge clk) begin
      if (srst) begin
        for (int j = 0; j < ISINC_TAPS; j++) begin
          dly_ff[j] <= '0;
        end
      end else if (tick) begin
        for (int j = 0; j < ISINC_TAPS; j++) begin
          dly_ff[j] <= line[j];
        end
      end
    end
  end

  // Inverse sinc saturation is reported (half-band clips are not flagged), since upstream back-off is the real remedy
  always_comb begin
    nxt_out = out_ff;
    nxt_strobe = 1'b0;
    nxt_under = 1'b0;
    nxt_sat = 1'b0;
    nxt_started = started_ff;
    if (tick) begin
      nxt_out = isinc_val;
      nxt_strobe = 1'b1;
      nxt_sat = |ch_sat;
      // Underrun only counts once the stream has begun
      nxt_under = started_ff && !tap_valid;
      nxt_started = started_ff || tap_valid;
    end
  end

  // Output registers
  always_ff @(posedge clk) begin
    if (srst) begin
      out_ff <= '0;
      strobe_ff <= 1'b0;
      under_ff <= 1'b0;
      sat_ff <= 1'b0;
      started_ff <= 1'b0;
    end else begin
      out_ff <= nxt_out;
      strobe_ff <= nxt_strobe;
      under_ff <= nxt_under;
      sat_ff <= nxt_sat;
      started_ff <= nxt_started;
    end
  end

  // Composite response comes from the fixed coefficient sets
  assign out_sample = out_ff;
  assign out_strobe = strobe_ff;
  assign underrun = under_ff;
  assign sat_hit = sat_ff;
endmodule

// [ifs_halfband.sv]
// Purpose: One interpolate-by-two half-band stage for all channels, polyphase form.
// Assumes: Input and output use valid/ready; one input gives two outputs.
// Notes: The zero-stuffed input is never built; each phase only sums taps that meet real samples.
`timescale 1ns/1ps
module ifs_halfband
  import ifs_pkg::*;
#(
  parameter int STAGE = 0,
  parameter int CH = NUM_CH,
  parameter int W = DATA_W
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [CH*W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [CH*W-1:0] out_data
);
  localparam int NH = (HB_TAPS[STAGE] + 1) / 4;
  localparam int L = 2 * NH;

  ifs_hb_state_e state_ff;
  ifs_hb_state_e nxt_state;
  logic [CH*W-1:0] out_ff;
  logic [CH*W-1:0] nxt_out;
  logic [CH*W-1:0] pend_ff;
  logic [CH*W-1:0] nxt_pend;
  logic [CH*W-1:0] even_val;
  logic [CH*W-1:0] odd_val;
  logic take;

  assign out_valid = (state_ff != IFS_HB_EMPTY);
  assign out_data = out_ff;
  // Accept a new sample when empty or when the odd phase leaves this cycle
  assign in_ready = (state_ff == IFS_HB_EMPTY) || ((state_ff == IFS_HB_ODD) && out_ready);
  assign take = in_valid && in_ready;

  for (genvar c = 0; c < CH; c++) begin : g_ch
    logic signed [W-1:0] dly_ff [L];
    logic signed [W-1:0] line [L];
    logic signed [ACC_W-1:0] acc;
    logic [W:0] rs;

    // Taps as the delay line will hold them after this sample enters
    always_comb begin
      line[0] = in_data[c*W +: W];
      for (int j = 1; j < L; j++) begin
        line[j] = dly_ff[j-1];
      end
      acc = '0;
      for (int j = 0; j < L; j++) begin
        acc = acc + ACC_W'(line[j]) * ACC_W'(HB_COEF[STAGE][(j < NH) ? j : (L - 1 - j)]);
      end
      rs = ifs_round_sat(acc, HB_SHIFT[STAGE]);
      even_val[c*W +: W] = rs[W-1:0];
      // Centre tap alone, scale of centre is unity gain
      odd_val[c*W +: W] = line[NH-1];
    end

    // Delay line moves once per accepted input sample
    always_ff @(posedge clk) begin
      if (srst) begin
        for (int j = 0; j < L; j++) begin
          dly_ff[j] <= '0;
        end
      end else if (take) begin
        for (int j = 0; j < L; j++) begin
          dly_ff[j] <= line[j];
        end
      end
    end
  end

  // Two outputs per input: even phase, then odd phase
  always_comb begin
    nxt_state = state_ff;
    nxt_out = out_ff;
    nxt_pend = pend_ff;
    unique case (state_ff)
      IFS_HB_EMPTY: begin
        if (take) begin
          nxt_out = even_val;
          nxt_pend = odd_val;
          nxt_state = IFS_HB_EVEN;
        end
      end
      IFS_HB_EVEN: begin
        if (out_ready) begin
          nxt_out = pend_ff;
          nxt_state = IFS_HB_ODD;
        end
      end
      IFS_HB_ODD: begin
        if (take) begin
          nxt_out = even_val;
          nxt_pend = odd_val;
          nxt_state = IFS_HB_EVEN;
        end else if (out_ready) begin
          nxt_state = IFS_HB_EMPTY;
        end
      end
      default: nxt_state = IFS_HB_EMPTY;
    endcase
  end

  // Sequencer registers
  always_ff @(posedge clk) begin
    if (srst) begin
      state_ff <= IFS_HB_EMPTY;
      out_ff <= '0;
      pend_ff <= '0;
    end else begin
      state_ff <= nxt_state;
      out_ff <= nxt_out;
      pend_ff <= nxt_pend;
    end
  end
endmodule

// [ifs_pkg.sv]
// Purpose: Shared constants, coefficient tables and helpers for the interpolation and sinc filter chain.
// Assumes: Two's complement samples, one clock at 25 MHz, all rates derived by enables.
// Notes: Half-band tables hold the outer nonzero taps of one side, outermost first.
package ifs_pkg;

  // Datapath shape
  localparam int DATA_W = 16;
  localparam int COEF_W = 18;
  localparam int ACC_W = 40;
  localparam int NUM_CH = 2;
  localparam int FIFO_DEPTH = 16;
  localparam int NUM_HB = 4;
  localparam int HB_MAX_HALF = 15;

  // Timing: converter update rate as a fraction of the system clock
  localparam int CLK_HZ = 25_000_000;
  localparam int UPDATE_RATE_HZ = 6_250_000;
  localparam int UPDATE_DIV = CLK_HZ / UPDATE_RATE_HZ;

  // Half-band stages: long, medium, short_a, short_b
  localparam int HB_TAPS [NUM_HB] = '{59, 23, 11, 11};
  localparam int HB_CENTRE [NUM_HB] = '{65536, 16384, 2048, 256};
  localparam int HB_SHIFT [NUM_HB] = '{16, 14, 11, 8};
  localparam int HB_COEF [NUM_HB][HB_MAX_HALF] = '{
    '{6, -19, 47, -100, 192, -342, 572, -914, 1409, -2119, 3152, -4729, 7420, -13334, 41527},
    '{-12, 84, -336, 1006, -2691, 10141, 0, 0, 0, 0, 0, 0, 0, 0, 0},
    '{29, -214, 1209, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0},
    '{3, -25, 150, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0}};

  // Inverse sinc: half of a symmetric 9-tap filter, centre last; taps sum to 512
  localparam int ISINC_TAPS = 9;
  localparam int ISINC_COEF [5] = '{1, -4, 13, -50, 592};
  localparam int ISINC_SHIFT = 9;

  // Reset values
  localparam logic [DATA_W-1:0] SAMPLE_RST = 16'h0000;

  // Half-band output sequencing
  typedef enum logic [2:0] {
    IFS_HB_EMPTY = 3'b001,
    IFS_HB_EVEN = 3'b010,
    IFS_HB_ODD = 3'b100
  } ifs_hb_state_e;

  // Round half up, shift right, clip to the sample range; bit DATA_W flags a clip
  function automatic logic [DATA_W:0] ifs_round_sat(input logic signed [ACC_W-1:0] acc, input int sh);
    logic signed [ACC_W-1:0] r;
    logic signed [ACC_W-1:0] hi;
    logic signed [ACC_W-1:0] lo;
    hi = ACC_W'(32767);
    lo = -ACC_W'(32768);
    r = (acc + (ACC_W'(1) <<< (sh - 1))) >>> sh;
    if (r > hi) begin
      ifs_round_sat = {1'b1, 16'h7fff};
    end else if (r < lo) begin
      ifs_round_sat = {1'b1, 16'h8000};
    end else begin
      ifs_round_sat = {1'b0, r[DATA_W-1:0]};
    end
  endfunction

endpackage

// [ifs_src_model.sv]
// Purpose: Upstream correction path stand-in feeding sample pairs.
// Assumes: Changes on the falling edge, holds a word until taken.
// Notes: Idle data toggles every cycle so a stale word never looks valid.
`timescale 1ns/1ps
module ifs_src_model (
  input wire logic clk,
  input wire logic srst,
  input wire logic run,
  input wire logic sq,
  input wire logic [31:0] level,
  input wire logic in_ready,
  output logic in_valid,
  output logic [31:0] in_data
);
  logic took = 1'b0;
  int cnt = 0;
  initial begin
    in_valid = 1'b0;
    in_data = 32'h0;
  end
  // Acceptance as the block samples it
  always @(posedge clk) took <= in_valid && in_ready && !srst;
  // Next word only after the last one was taken; square mode skips back-off on purpose
  always @(negedge clk) begin
    if (took) cnt <= cnt + 1;
    if (took || !in_valid) begin
      if (run) begin
        in_valid <= 1'b1;
        in_data <= sq ? (cnt[2] ? ~level : level) :
          {16'($signed(level[31:16]) >>> 1), 16'($signed(level[15:0]) >>> 1)};
      end else begin
        in_valid <= 1'b0;
        in_data <= ~in_data;
      end
    end
  end
endmodule

// [interpolation_and_sinc_filters_tb.sv]
// Purpose: Self-checking bench for the interpolation and sinc chain.
// Assumes: DC gain of each stage is one, so settled outputs equal the input.
// Notes: Outputs with underrun are skipped; their zero fill enters the inverse sinc line and reaches out_sample four strobes later.
`timescale 1ns/1ps
module interpolation_and_sinc_filters_tb;
  import ifs_pkg::*;
  logic clk = 1'b0, srst = 1'b1, isinc_en = 1'b0, run = 1'b0, sq = 1'b0, seen;
  logic in_valid, in_ready, out_strobe, underrun, sat_hit;
  logic [1:0] interp_sel = 2'h0;
  logic [31:0] level = 32'h0, in_data, out_sample, lfsr = 32'ha9bbeeca;
  logic [4:0] fifo_level;
  int n_errors = 0, n_tests = 0, cyc = 0;
  ifs_filter_top u_ifs_filter_top (.clk(clk), .srst(srst), .interp_sel(interp_sel), .isinc_en(isinc_en),
    .in_valid(in_valid), .in_ready(in_ready), .in_data(in_data), .out_sample(out_sample),
    .out_strobe(out_strobe), .underrun(underrun), .sat_hit(sat_hit), .fifo_level(fifo_level));
  ifs_src_model u_ifs_src_model (.clk(clk), .srst(srst), .run(run), .sq(sq), .level(level),
    .in_ready(in_ready), .in_valid(in_valid), .in_data(in_data));
  always #20 clk = ~clk;
  // Hang guard well above the planned run length
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      n_errors++;
      finish_test();
    end
  end
  function automatic logic [31:0] next_rand(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // DC model: summed taps, round half up, clip, stage by stage
  function automatic int model_dc(input int x, input int sel, input bit isn);
    longint acc;
    int y, s;
    y = x;
    for (int k = 0; k <= sel + (isn ? 1 : 0); k++) begin
      s = (k > sel) ? ISINC_COEF[4] : 0;
      for (int t = 0; t < 4 && k > sel; t++) s += 2 * ISINC_COEF[t];
      for (int t = 0; t < HB_MAX_HALF && k <= sel; t++) s += 2 * HB_COEF[k][t];
      acc = longint'(y) * s;
      acc = (acc + (longint'(1) <<< ((k > sel ? ISINC_SHIFT : HB_SHIFT[k]) - 1))) >>> (k > sel ? ISINC_SHIFT : HB_SHIFT[k]);
      y = acc > 32767 ? 32767 : acc < -32768 ? -32768 : int'(acc);
    end
    return y;
  endfunction
  task automatic cmp_word(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cmp_flag(input string what, input logic exp, input logic got);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %b seen %b", what, exp, got);
    end
  endtask
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // Reset for two cycles; outputs checked while still held
  task automatic do_reset();
    run = 1'b0;
    srst = 1'b1;
    repeat (2) @(negedge clk);
    cmp_word("reset out_sample", 32'h0, out_sample);
    cmp_word("reset fifo_level", 32'h0, 32'(fifo_level));
    cmp_flag("reset in_ready", 1'b1, in_ready);
    srst = 1'b0;
  endtask
  // Random DC pair through one mode, compared at every strobe once settled
  task automatic run_mode(input int sel, input bit isn);
    logic [31:0] exp;
    int n_strobe = 0;
    interp_sel = 2'(sel);
    isinc_en = isn;
    lfsr = next_rand(lfsr);
    level = lfsr;
    exp[15:0] = 16'(model_dc(int'($signed(level[15:0])) >>> 1, sel, isn));
    exp[31:16] = 16'(model_dc(int'($signed(level[31:16])) >>> 1, sel, isn));
    do_reset();
    run = 1'b1;
    repeat (2000 << sel) @(negedge clk);
    repeat (400) begin
      @(negedge clk);
      if (out_strobe === 1'b1) begin
        n_strobe++;
        if (sel < 2) cmp_flag("underrun", 1'b0, underrun);
        cmp_flag("sat_hit", 1'b0, sat_hit);
        if (underrun !== 1'b1) cmp_word("out_sample", exp, out_sample);
      end
    end
    // One strobe per update enable, so the window holds exactly a quarter of its cycles
    cmp_word("strobe count", 32'h64, 32'(n_strobe));
  endtask
  // Every rate without inverse sinc, interp_sel 0 and 1 also with it; fill, drain, then a clipping square wave
  initial begin
    for (int s = 0; s < 4; s++) begin
      for (int e = 0; e < 2; e++) begin
        if (s < 2 || e == 0) run_mode(s, e[0]);
      end
    end
    // A pop leaves one cycle at fifteen before the source refills it
    for (int i = 0; i < 8 && fifo_level !== 5'h10; i++) @(negedge clk);
    cmp_word("full fifo_level", 32'h10, 32'(fifo_level));
    cmp_flag("full in_ready", 1'b0, in_ready);
    run = 1'b0;
    for (int i = 0; i < 4000 && fifo_level !== 5'h0; i++) @(negedge clk);
    cmp_word("drained fifo_level", 32'h0, 32'(fifo_level));
    interp_sel = 2'h0;
    isinc_en = 1'b1;
    sq = 1'b1;
    level = 32'h7fff7fff;
    do_reset();
    run = 1'b1;
    seen = 1'b0;
    repeat (3000) begin
      @(negedge clk);
      seen = seen | (sat_hit === 1'b1);
    end
    cmp_flag("sat_seen", 1'b1, seen);
    // Starve the started chain: zero fill with an underrun pulse at each strobe
    run = 1'b0;
    repeat (400) @(negedge clk);
    for (int i = 0; i < 8 && out_strobe !== 1'b1; i++) @(negedge clk);
    cmp_flag("starved underrun", 1'b1, underrun);
    cmp_word("starved out_sample", 32'h0, out_sample);
    finish_test();
  end
endmodule
